// ==== dv/vpi_core_model.sv ====
`timescale 1ns/100ps
module vpi_core_model
(
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        irq_req,
   input  wire logic [15:0] irq_vector,
   input  wire logic        auto_ack,
   input  wire logic [3:0]  ack_delay,
   input  wire logic        ret_req,
   output logic             irq_ack,
   output logic             irq_return,
   output logic      [15:0] taken_vector
);
   logic [3:0] wait_cnt;

   // Acknowledge once the offer has stood ack_delay + 1 cycles
   always_ff @(posedge sys_clk)
   begin
      if (!rstn || irq_ack)
      begin
         irq_ack  <= 1'h0;
         wait_cnt <= 4'h0;
      end
      else if (auto_ack && irq_req && wait_cnt >= ack_delay)
         irq_ack <= 1'h1;
      else if (irq_req)
         wait_cnt <= wait_cnt + 4'h1;
      else
         wait_cnt <= 4'h0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         taken_vector <= 16'h0000;
      else if (irq_ack && irq_req)
         taken_vector <= irq_vector;
   end

   always_ff @(posedge sys_clk)
   begin
      irq_return <= rstn & ret_req;
   end
endmodule

// ==== dv/vpi_unit_tb.sv ====
`timescale 1ns/100ps
module vpi_unit_tb;
   logic        sys_clk;
   logic        rstn;
   logic [3:0]  pins;
   logic [16:0] unit_event;
   logic [20:0] src_enable;
   logic [20:0] src_clear;
   logic [9:0]  vec_level_hi;
   logic        auto_ack;
   logic [3:0]  ack_delay;
   logic        ret_req;
   logic        irq_ack;
   logic        irq_return;
   logic        irq_req;
   logic [15:0] irq_vector;
   logic [1:0]  irq_level;
   logic [1:0]  service_level;
   logic [20:0] src_flags;
   logic [15:0] taken_vector;
   int          errors;
   int          compares;
   int          vec_of [21] = '{0, 1, 2, 2, 3, 3, 3, 4, 5, 5, 6, 6, 7, 7, 8, 8, 8, 8, 9, 9, 9};

   vpi_unit dut_u
   (
      .sys_clk           (sys_clk),
      .rstn              (rstn),
      .ext_pin_request_a (pins[0]),
      .ext_pin_request_b (pins[1]),
      .ext_pin_request_c (pins[2]),
      .ext_pin_request_d (pins[3]),
      .unit_event        (unit_event),
      .src_enable        (src_enable),
      .src_clear         (src_clear),
      .vec_level_hi      (vec_level_hi),
      .irq_ack           (irq_ack),
      .irq_return        (irq_return),
      .irq_req           (irq_req),
      .irq_vector        (irq_vector),
      .irq_level         (irq_level),
      .service_level     (service_level),
      .src_flags         (src_flags)
   );

   vpi_core_model core_u
   (
      .sys_clk      (sys_clk),
      .rstn         (rstn),
      .irq_req      (irq_req),
      .irq_vector   (irq_vector),
      .auto_ack     (auto_ack),
      .ack_delay    (ack_delay),
      .ret_req      (ret_req),
      .irq_ack      (irq_ack),
      .irq_return   (irq_return),
      .taken_vector (taken_vector)
   );

   task automatic end_of_test;
      if (errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask

   // Wait on irq_req (sel 0) or service_level (sel 1)
   task automatic wait_for(input int sel, input logic [1:0] v);
      int n;
      n = 0;
      while ((sel == 0 ? {1'h0, irq_req} : service_level) !== v && n < 40)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if ((sel == 0 ? {1'h0, irq_req} : service_level) !== v)
      begin
         errors++;
         $display("mismatch %0t wait ran out", $time);
         end_of_test();
      end
   endtask

   task automatic fire(input int s);
      @(posedge sys_clk);
      if (s == 0 || s == 1 || s == 2 || s == 4)
         pins[s == 4 ? 3 : s] <= 1'h1;
      else
         unit_event[s == 3 ? 0 : s - 4] <= 1'h1;
      @(posedge sys_clk);
      unit_event <= 17'h0;
      repeat (3) @(posedge sys_clk);
      pins <= 4'h0;
      #1;
   endtask

   task automatic clear_src(input logic [20:0] m);
      @(posedge sys_clk);
      src_clear <= m;
      @(posedge sys_clk);
      src_clear <= 21'h0;
      #1;
   endtask

   task automatic ret;
      @(posedge sys_clk);
      ret_req <= 1'h1;
      @(posedge sys_clk);
      ret_req <= 1'h0;
      #1;
   endtask

   task automatic t_reset;
      cmp(irq_req, 32'h0, "req");
      cmp(irq_vector, 32'h3, "vector");
      cmp(service_level, 32'h0, "service");
      cmp(src_flags, 32'h0, "flags");
   endtask

   // Every source alone, level select alternating
   task automatic t_map;
      int   v;
      logic hi;
      for (int s = 0; s < 21; s++)
      begin
         v = vec_of[s];
         hi = s[0];
         @(posedge sys_clk);
         vec_level_hi <= 10'(hi) << v;
         fire(s);
         wait_for(0, 2'h1);
         cmp(src_flags, 32'(21'h1 << s), "flags");
         cmp(irq_vector, 32'(16'h0003 + 16'(8 * v)), "vector");
         cmp(irq_level, hi ? (v < 2 ? 32'h3 : 32'h2) : 32'h1, "level");
         clear_src(21'h1 << s);
         wait_for(0, 2'h0);
      end
   endtask

   task automatic t_tie;
      @(posedge sys_clk);
      vec_level_hi <= 10'h000;
      unit_event <= 17'h04008;
      @(posedge sys_clk);
      unit_event <= 17'h0;
      wait_for(0, 2'h1);
      cmp(irq_vector, 32'h23, "tie");
      @(posedge sys_clk);
      vec_level_hi <= 10'h200;
      repeat (3) @(posedge sys_clk);
      #1;
      cmp(irq_vector, 32'h4B, "level win");
      cmp(irq_level, 32'h2, "level");
      @(posedge sys_clk);
      src_enable <= ~(21'h1 << 18);
      repeat (3) @(posedge sys_clk);
      #1;
      cmp(irq_vector, 32'h23, "disabled");
      clear_src(21'h1FFFFF);
      @(posedge sys_clk);
      src_enable <= 21'h1FFFFF;
      #1;
      wait_for(0, 2'h0);
   endtask

   task automatic t_nest;
      @(posedge sys_clk);
      auto_ack <= 1'h1;
      vec_level_hi <= 10'h041;
      fire(8);
      wait_for(1, 2'h1);
      cmp(taken_vector, 32'h2B, "low taken");
      clear_src(21'h1 << 8);
      fire(3);
      repeat (10) @(posedge sys_clk);
      #1;
      cmp(irq_req, 32'h0, "equal refused");
      fire(10);
      wait_for(1, 2'h2);
      cmp(taken_vector, 32'h33, "high nests");
      clear_src(21'h1 << 10);
      fire(0);
      wait_for(1, 2'h3);
      cmp(taken_vector, 32'h03, "top nests");
      clear_src(21'h1);
      ret();
      wait_for(1, 2'h2);
      ret();
      wait_for(1, 2'h1);
      repeat (10) @(posedge sys_clk);
      #1;
      cmp(irq_req, 32'h0, "still refused");
      @(posedge sys_clk);
      ack_delay <= 4'h0;
      ret();
      wait_for(0, 2'h1);
      wait_for(1, 2'h1);
      cmp(taken_vector, 32'h13, "resumed");
      clear_src(21'h1 << 3);
      ret();
      wait_for(1, 2'h0);
   endtask

   initial
   begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end

   initial
   begin
      errors = 0;
      compares = 0;
      rstn = 1'h0;
      pins = 4'h0;
      unit_event = 17'h0;
      src_enable = 21'h1FFFFF;
      src_clear = 21'h0;
      vec_level_hi = 10'h0;
      auto_ack = 1'h0;
      ack_delay = 4'h3;
      ret_req = 1'h0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'h1;
      #1;
      t_reset();
      t_map();
      t_tie();
      t_nest();
      end_of_test();
   end
endmodule

// ==== rtl/vpi_arbiter.sv ====
`timescale 1ns/100ps
module vpi_arbiter
(
   input  wire logic [vpi_pkg::NUM_VEC-1:0] vec_pend,
   input  wire logic [vpi_pkg::NUM_VEC-1:0] vec_level_hi,
   input  wire logic [1:0]                  cur_level,
   output logic                             grant_valid,
   output logic      [3:0]                  grant_idx,
   output logic      [1:0]                  grant_level
);
   logic [1:0] lvl;

   // Descending scan with >= leaves the lowest vector on ties
   always_comb
   begin
      lvl         = vpi_pkg::LVL_NONE;
      grant_valid = 1'b0;
      grant_idx   = 4'h0;
      grant_level = vpi_pkg::LVL_NONE;
      for (int k = vpi_pkg::NUM_VEC - 1; k >= 0; k--)
      begin
         lvl = vpi_pkg::vec_level(k, vec_level_hi[k]);
         if (vec_pend[k] && (lvl > cur_level) && (lvl >= grant_level))
         begin
            grant_valid = 1'b1;
            grant_idx   = 4'(k);
            grant_level = lvl;
         end
      end
   end
endmodule

// ==== rtl/vpi_pin_sync.sv ====
`timescale 1ns/100ps
module vpi_pin_sync
(
   input  wire logic                              sys_clk,
   input  wire logic                              rstn,
   input  wire logic [vpi_pkg::PIN_COUNT-1:0]     pin,
   output logic      [vpi_pkg::PIN_COUNT-1:0]     rise
);
   logic [vpi_pkg::PIN_COUNT-1:0] stage_a;
   logic [vpi_pkg::PIN_COUNT-1:0] stage_b;
   logic [vpi_pkg::PIN_COUNT-1:0] stage_c;
   logic [vpi_pkg::PIN_COUNT-1:0] accepted;
   logic [vpi_pkg::PIN_COUNT-1:0] agree;

   assign agree = ~(stage_b ^ stage_c);

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         stage_a <= '0;
         stage_b <= '0;
         stage_c <= '0;
      end
      else
      begin
         stage_a <= pin;
         stage_b <= stage_a;
         stage_c <= stage_b;
      end
   end

   // Level only moves once the last two stages agree
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         accepted <= '0;
         rise     <= '0;
      end
      else
      begin
         accepted <= (agree & stage_c) | (~agree & accepted);
         rise     <= agree & stage_c & ~accepted;
      end
   end
endmodule

// ==== rtl/vpi_pkg.sv ====
// Contract
// - Three nesting levels, top over high over low
// - Equal or lower level than in-service refused
// - Highest assigned level wins among pending vectors
// - Equal level ties go to lowest vector
// - 21 sources share 10 vectors, flags kept
// - Vector 1BH: pin d, base timer, calendar
// - Vector 33H: sync serial a, async receive
// - Vector 3BH: serial unit b, async send
// - Vector 43H: converter, timers six/seven, SPI
// - Vector 4BH: port 0, timers four/five
package vpi_pkg;

   localparam int NUM_SRC = 21;
   localparam int NUM_VEC = 10;

   // Source slots, grouped by vector in ascending order
   localparam int SRC_EXT_PIN_REQUEST_A    = 0;
   localparam int SRC_EXT_PIN_REQUEST_B    = 1;
   localparam int SRC_EXT_PIN_REQUEST_C    = 2;
   localparam int SRC_TIMER_ZERO_LOW       = 3;
   localparam int SRC_EXT_PIN_REQUEST_D    = 4;
   localparam int SRC_BASE_TIMER           = 5;
   localparam int SRC_CALENDAR             = 6;
   localparam int SRC_TIMER_ZERO_HIGH      = 7;
   localparam int SRC_TIMER_ONE_LOW        = 8;
   localparam int SRC_TIMER_ONE_HIGH       = 9;
   localparam int SRC_SYNC_SERIAL_A        = 10;
   localparam int SRC_SECOND_ASYNC_RX      = 11;
   localparam int SRC_SERIAL_UNIT_B        = 12;
   localparam int SRC_ASYNC_TX             = 13;
   localparam int SRC_CONVERTER_DONE       = 14;
   localparam int SRC_TIMER_SIX            = 15;
   localparam int SRC_TIMER_SEVEN          = 16;
   localparam int SRC_SPI_RX               = 17;
   localparam int SRC_PORT_ZERO            = 18;
   localparam int SRC_TIMER_FOUR           = 19;
   localparam int SRC_TIMER_FIVE           = 20;

   // One past the last source slot of each vector
   localparam int VEC_LAST [NUM_VEC] = '{1, 2, 4, 7, 8, 10, 12, 14, 18, 21};

   localparam logic [15:0] VEC_ADDR_BASE = 16'h0003;
   localparam logic [15:0] VEC_ADDR_STEP = 16'h0008;

   localparam logic [1:0] LVL_NONE = 2'h0;
   localparam logic [1:0] LVL_LOW  = 2'h1;
   localparam logic [1:0] LVL_HIGH = 2'h2;
   localparam logic [1:0] LVL_TOP  = 2'h3;

   localparam int TOP_CAPABLE_VECS = 2;
   localparam int PIN_COUNT        = 4;

   function automatic logic [3:0] src_vector(input int src);
      logic [3:0] v;
      v = 4'h0;
      for (int k = NUM_VEC - 1; k >= 0; k--)
      begin
         if (src < VEC_LAST[k])
            v = 4'(k);
      end
      return v;
   endfunction

   function automatic logic [1:0] vec_level(input int vec, input logic sel_hi);
      logic [1:0] l;
      l = LVL_LOW;
      if (sel_hi)
         l = (vec < TOP_CAPABLE_VECS) ? LVL_TOP : LVL_HIGH;
      return l;
   endfunction

   function automatic logic [15:0] vec_addr(input logic [3:0] vec);
      return VEC_ADDR_BASE + 16'(vec * VEC_ADDR_STEP);
   endfunction

endpackage

// ==== rtl/vpi_unit.sv ====
`timescale 1ns/100ps
module vpi_unit
(
   input  wire logic                          sys_clk,
   input  wire logic                          rstn,
   input  wire logic                          ext_pin_request_a,
   input  wire logic                          ext_pin_request_b,
   input  wire logic                          ext_pin_request_c,
   input  wire logic                          ext_pin_request_d,
   input  wire logic [16:0]                   unit_event,
   input  wire logic [vpi_pkg::NUM_SRC-1:0]   src_enable,
   input  wire logic [vpi_pkg::NUM_SRC-1:0]   src_clear,
   input  wire logic [vpi_pkg::NUM_VEC-1:0]   vec_level_hi,
   input  wire logic                          irq_ack,
   input  wire logic                          irq_return,
   output logic                               irq_req,
   output logic      [15:0]                   irq_vector,
   output logic      [1:0]                    irq_level,
   output logic      [1:0]                    service_level,
   output logic      [vpi_pkg::NUM_SRC-1:0]   src_flags
);
   typedef enum logic [1:0]
   {
      VPI_ST_IDLE  = 2'b00,
      VPI_ST_OFFER = 2'b01,
      VPI_ST_TAKEN = 2'b11
   } vpi_state_type;

   vpi_state_type                state;
   logic [vpi_pkg::PIN_COUNT-1:0] pin_rise;
   logic [vpi_pkg::NUM_SRC-1:0]   src_event;
   logic [vpi_pkg::NUM_VEC-1:0]   vec_pend;
   logic [2:0]                    in_service;
   logic [2:0]                    next_in_service;
   logic [1:0]                    cur_level;
   logic                          arb_valid;
   logic [3:0]                    arb_idx;
   logic [1:0]                    arb_level;
   logic [3:0]                    held_idx;

   function automatic logic [1:0] top_level(input logic [2:0] bits);
      logic [1:0] l;
      l = vpi_pkg::LVL_NONE;
      if (bits[0])
         l = vpi_pkg::LVL_LOW;
      if (bits[1])
         l = vpi_pkg::LVL_HIGH;
      if (bits[2])
         l = vpi_pkg::LVL_TOP;
      return l;
   endfunction

   vpi_pin_sync u_pin_sync
   (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pin     ({ext_pin_request_d, ext_pin_request_c, ext_pin_request_b, ext_pin_request_a}),
      .rise    (pin_rise)
   );

   // Pin edges and unit events laid into source slots
   always_comb
   begin
      src_event                                  = '0;
      src_event[vpi_pkg::SRC_EXT_PIN_REQUEST_A]  = pin_rise[0];
      src_event[vpi_pkg::SRC_EXT_PIN_REQUEST_B]  = pin_rise[1];
      src_event[vpi_pkg::SRC_EXT_PIN_REQUEST_C]  = pin_rise[2];
      src_event[vpi_pkg::SRC_TIMER_ZERO_LOW]     = unit_event[0];
      src_event[vpi_pkg::SRC_EXT_PIN_REQUEST_D]  = pin_rise[3];
      src_event[vpi_pkg::SRC_BASE_TIMER]         = unit_event[1];
      src_event[vpi_pkg::SRC_CALENDAR]           = unit_event[2];
      src_event[vpi_pkg::SRC_TIMER_ZERO_HIGH]    = unit_event[3];
      src_event[vpi_pkg::SRC_TIMER_ONE_LOW]      = unit_event[4];
      src_event[vpi_pkg::SRC_TIMER_ONE_HIGH]     = unit_event[5];
      src_event[vpi_pkg::SRC_SYNC_SERIAL_A]      = unit_event[6];
      src_event[vpi_pkg::SRC_SECOND_ASYNC_RX]    = unit_event[7];
      src_event[vpi_pkg::SRC_SERIAL_UNIT_B]      = unit_event[8];
      src_event[vpi_pkg::SRC_ASYNC_TX]           = unit_event[9];
      src_event[vpi_pkg::SRC_CONVERTER_DONE]     = unit_event[10];
      src_event[vpi_pkg::SRC_TIMER_SIX]          = unit_event[11];
      src_event[vpi_pkg::SRC_TIMER_SEVEN]        = unit_event[12];
      src_event[vpi_pkg::SRC_SPI_RX]             = unit_event[13];
      src_event[vpi_pkg::SRC_PORT_ZERO]          = unit_event[14];
      src_event[vpi_pkg::SRC_TIMER_FOUR]         = unit_event[15];
      src_event[vpi_pkg::SRC_TIMER_FIVE]         = unit_event[16];
   end

   // Sticky source flags, a new event beats a clear
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         src_flags <= '0;
      else
         src_flags <= (src_flags & ~src_clear) | src_event;
   end

   // Shared vectors: any enabled flag of the group raises it
   always_comb
   begin
      vec_pend = '0;
      for (int s = 0; s < vpi_pkg::NUM_SRC; s++)
      begin
         if (src_flags[s] && src_enable[s])
            vec_pend[vpi_pkg::src_vector(s)] = 1'b1;
      end
   end

   assign cur_level = top_level(in_service);

   vpi_arbiter u_arbiter
   (
      .vec_pend     (vec_pend),
      .vec_level_hi (vec_level_hi),
      .cur_level    (cur_level),
      .grant_valid  (arb_valid),
      .grant_idx    (arb_idx),
      .grant_level  (arb_level)
   );

   // One bit per level; a return retires the highest, an ack adds its own
   always_comb
   begin
      next_in_service = in_service;
      if (irq_return)
      begin
         if (in_service[2])
            next_in_service[2] = 1'b0;
         else if (in_service[1])
            next_in_service[1] = 1'b0;
         else
            next_in_service[0] = 1'b0;
      end
      if (irq_ack && irq_req && (irq_level != vpi_pkg::LVL_NONE))
         next_in_service[irq_level - 2'h1] = 1'b1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         in_service    <= 3'h0;
         service_level <= vpi_pkg::LVL_NONE;
      end
      else
      begin
         in_service    <= next_in_service;
         service_level <= top_level(next_in_service);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         state <= VPI_ST_IDLE;
      else
      begin
         case (state)
            VPI_ST_IDLE:
               if (arb_valid)
                  state <= VPI_ST_OFFER;
            VPI_ST_OFFER:
               if (irq_ack)
                  state <= VPI_ST_TAKEN;
               else if (!arb_valid)
                  state <= VPI_ST_IDLE;
            VPI_ST_TAKEN:
               state <= VPI_ST_IDLE;
            default:
               state <= VPI_ST_IDLE;
         endcase
      end
   end

   // Offer follows the arbiter each cycle until the core takes it
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         irq_req    <= 1'b0;
         irq_vector <= vpi_pkg::VEC_ADDR_BASE;
         irq_level  <= vpi_pkg::LVL_NONE;
         held_idx   <= 4'h0;
      end
      else
      begin
         case (state)
            VPI_ST_IDLE, VPI_ST_OFFER:
            begin
               if ((state == VPI_ST_OFFER) && irq_ack)
                  irq_req <= 1'b0;
               else
               begin
                  irq_req <= arb_valid;
                  if (arb_valid)
                  begin
                     irq_vector <= vpi_pkg::vec_addr(arb_idx);
                     irq_level  <= arb_level;
                     held_idx   <= arb_idx;
                  end
               end
            end
            default:
               irq_req <= 1'b0;
         endcase
      end
   end

   // Independent reference for the arbitration checks
   logic [1:0] ref_level;
   logic [3:0] ref_idx;
   logic       ref_found;

   always_comb
   begin
      ref_level = vpi_pkg::LVL_NONE;
      ref_idx   = 4'h0;
      ref_found = 1'b0;
      for (int k = 0; k < vpi_pkg::NUM_VEC; k++)
      begin
         if (vec_pend[k] && (vpi_pkg::vec_level(k, vec_level_hi[k]) > ref_level))
            ref_level = vpi_pkg::vec_level(k, vec_level_hi[k]);
      end
      for (int k = vpi_pkg::NUM_VEC - 1; k >= 0; k--)
      begin
         if (vec_pend[k] && (vpi_pkg::vec_level(k, vec_level_hi[k]) == ref_level))
         begin
            ref_idx   = 4'(k);
            ref_found = 1'b1;
         end
      end
   end

   default clocking vpi_cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   a_level_order: assert property (
      irq_ack && irq_req |=> service_level == $past(irq_level) && service_level > $past(cur_level))
      else $error("Acked level not entered in service");
   a_nest_refuse: assert property (
      irq_req |-> irq_level > cur_level)
      else $error("Offer not above level in service");

   // Arbitration against the reference
   a_top_level_wins: assert property (
      ref_found && ref_level > cur_level |-> arb_valid && arb_level == ref_level)
      else $error("Grant not at highest pending level");
   a_lowest_vector: assert property (
      ref_found && ref_level > cur_level |-> arb_valid && arb_idx == ref_idx)
      else $error("Tie not granted to lowest vector");
   a_flag_sticky: assert property (
      src_event != '0 |=> (src_flags & $past(src_event)) == $past(src_event))
      else $error("Source event lost");

   // Shared vector groups
   a_vec_1b_share: assert property (
      vec_pend[3] == |(src_flags[6:4] & src_enable[6:4]))
      else $error("Vector 1BH sharing wrong");
   a_vec_33_share: assert property (
      vec_pend[6] == |(src_flags[11:10] & src_enable[11:10]))
      else $error("Vector 33H sharing wrong");
   a_vec_3b_share: assert property (
      vec_pend[7] == |(src_flags[13:12] & src_enable[13:12]))
      else $error("Vector 3BH sharing wrong");
   a_vec_43_share: assert property (
      vec_pend[8] == |(src_flags[17:14] & src_enable[17:14]))
      else $error("Vector 43H sharing wrong");
   a_vec_4b_share: assert property (
      vec_pend[9] == |(src_flags[20:18] & src_enable[20:18]))
      else $error("Vector 4BH sharing wrong");
   a_pin_vec_level: assert property (
      irq_req && held_idx < 4'h2 |-> irq_level == (vec_level_hi[held_idx] ?
         vpi_pkg::LVL_TOP : vpi_pkg::LVL_LOW) || $changed(vec_level_hi))
      else $error("Pin vector level not top or low");
   a_timer_vec_level: assert property (
      irq_req && held_idx >= 4'h2 |-> irq_level != vpi_pkg::LVL_TOP
         && irq_vector == vpi_pkg::vec_addr(held_idx))
      else $error("Shared vector level or address wrong");

   // Offer handshake and nesting bookkeeping
   a_ack_release: assert property (
      irq_ack && irq_req |=> !irq_req ##1 !irq_req)
      else $error("Offer not withdrawn after ack");
   a_taken_level: assert property (
      state == VPI_ST_TAKEN |-> service_level != vpi_pkg::LVL_NONE)
      else $error("Taken offer left no level in service");
   a_return_pop: assert property (
      irq_return && !(irq_ack && irq_req) && service_level != vpi_pkg::LVL_NONE
         |=> service_level < $past(service_level))
      else $error("Return did not retire the highest level");
   a_flag_clear: assert property (
      src_clear != '0 |=> (src_flags & $past(src_clear & ~src_event)) == '0)
      else $error("Cleared source flag still set");
   a_enable_gate: assert property (
      (src_flags & src_enable) == '0 |-> vec_pend == '0)
      else $error("Vector raised with no enabled flag");
   a_pin_flag: assert property (
      pin_rise[0] |=> src_flags[vpi_pkg::SRC_EXT_PIN_REQUEST_A])
      else $error("Pin edge did not set its flag");

   // Main scenarios reached

   c_nest_three: cover property (in_service == 3'h7);
   c_ack_offer: cover property (irq_req && irq_ack ##1 !irq_req ##[1:20] irq_req);
   c_shared_tie: cover property (vec_pend[8] && vec_pend[9] && arb_valid);
   c_return_pop: cover property (irq_return && in_service[2] && in_service[0]);
   c_pin_top: cover property (irq_req && irq_level == vpi_pkg::LVL_TOP);
endmodule
